//--- bench/citl_src_model.sv
`timescale 1ns/1ps
module citl_src_model (
  // Clock
  input wire logic mclk_i,
  // Request lines
  output logic [31:0] irq_o,
  output logic nmi_o,
  output logic werr_o,
  output logic [31:0] int_o
);
  initial
  begin
    irq_o = 32'h0;
    nmi_o = 1'b0;
    werr_o = 1'b0;
    int_o = 32'h0;
  end
  // Level lines stay up until the test drops them with another hold call
  task automatic hold(input int k, input int i, input logic v);
    if (k == 0)
      irq_o[i] <= v;
    else
      int_o[i] <= v;
  endtask
  // Edges last four cycles so the input synchroniser sees them
  task automatic pulse(input int k, input int i);
    if (k == 0)
      irq_o[i] <= 1'b1;
    else if (k == 1)
      nmi_o <= 1'b1;
    else
      werr_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    nmi_o <= 1'b0;
    werr_o <= 1'b0;
    if (k == 0)
      irq_o[i] <= 1'b0;
  endtask
endmodule

//--- bench/citl_sva.sv
`timescale 1ns/1ps
module citl_sva
  import citl_pkg::*;
#(
  parameter logic [3:0] c_callable_level_limit = 4'h3
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Sources and dispatch
  input wire logic nmi_i,
  input wire logic disp_valid_o,
  input wire logic [3:0] disp_level_o,
  input wire logic disp_nmi_o,
  input wire logic disp_c_ok_o,
  input wire logic irq_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    $rose(avs_read || avs_write);
  endsequence
  sequence s_ans;
    ##[1:3] !avs_waitrequest;
  endsequence
  a_bus_answer: assert property (s_req |-> s_ans)
    else $error("bus request not answered");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_idle_wait: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low while idle");
  a_nmi_level: assert property (disp_nmi_o |-> disp_valid_o &&
    disp_level_o == CITL_NMI_LEVEL)
    else $error("unmaskable dispatch at wrong level");
  a_nmi_catch: assert property ($rose(nmi_i) |-> ##[1:8] disp_nmi_o)
    else $error("unmaskable edge not dispatched");
  a_nmi_hold: assert property ($fell(disp_nmi_o) |->
    $past(avs_write) || $past(avs_write, 2))
    else $error("unmaskable request dropped uncleared");
  a_c_ok_flag: assert property (disp_valid_o && !disp_nmi_o |->
    disp_c_ok_o == (disp_level_o == 4'h1 ||
    disp_level_o <= c_callable_level_limit))
    else $error("handler class flag wrong");
  a_level_range: assert property (disp_valid_o |-> disp_level_o != 4'h0)
    else $error("dispatch at level zero");
  a_irq_drop: assert property ($fell(irq_o) |->
    $past(avs_write) || $past(avs_write, 2))
    else $error("interrupt dropped without write");
endmodule

bind citl_top citl_sva #(
  .c_callable_level_limit(c_callable_level_limit)
) u_sva (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .nmi_i(nmi_i),
  .disp_valid_o(disp_valid_o),
  .disp_level_o(disp_level_o),
  .disp_nmi_o(disp_nmi_o),
  .disp_c_ok_o(disp_c_ok_o),
  .irq_o(irq_o)
);

//--- bench/core_interrupt_and_timer_logic_test.sv
`timescale 1ns/1ps
module core_interrupt_and_timer_logic_test
  import citl_pkg::*;
;
  localparam logic [63:0] TYPES = {{28{CITL_TYPE_EDGE}}, CITL_TYPE_SW,
    CITL_TYPE_INT, CITL_TYPE_EDGE, CITL_TYPE_LEVEL};
  localparam logic [127:0] LVLS = {{30{4'h1}}, 4'h3, 4'h1};
  logic mclk_i, rst_i, avs_read, avs_write, avs_waitrequest;
  logic nmi_i, wr_resp_err_i, disp_valid_o, disp_nmi_o, disp_c_ok_o, irq_o;
  logic [7:0] avs_address;
  logic [3:0] disp_level_o;
  logic [31:0] avs_writedata, avs_readdata, irq_i, int_src_i;
  logic [31:0] q, c0, t0, cyc, t_smp;
  int num_errors, check_count;

  citl_top #(.SRC_TYPE(TYPES), .SRC_LEVEL(LVLS)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_i(irq_i), .nmi_i(nmi_i), .wr_resp_err_i(wr_resp_err_i),
    .int_src_i(int_src_i), .disp_valid_o(disp_valid_o),
    .disp_level_o(disp_level_o), .disp_nmi_o(disp_nmi_o),
    .disp_c_ok_o(disp_c_ok_o), .irq_o(irq_o));
  citl_src_model u_src (.mclk_i(mclk_i), .irq_o(irq_i), .nmi_o(nmi_i),
    .werr_o(wr_resp_err_i), .int_o(int_src_i));

  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) cyc <= cyc + 32'h1;

  task automatic close_out();
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge mclk_i);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk_i);
    q = avs_readdata;
    t_smp = cyc;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic pend(input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, CITL_OFS_PEND, 32'h0);
    chk(q & m, e);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq_o}, {31'h0, e});
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    close_out();
  end

  initial
  begin
    rst_i = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    cyc = 32'h0;
    num_errors = 0;
    check_count = 0;
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    bus(1'b0, CITL_OFS_CMP2, 32'h0);
    chk(q, CITL_CMP_RST);
    bus(1'b1, 8'h3C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h3C, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, CITL_OFS_CFG, 32'h0);
    chk(q, 32'h0000_8303);
    bus(1'b0, CITL_OFS_CCNT, 32'h0);
    c0 = q;
    t0 = t_smp;
    bus(1'b0, CITL_OFS_CCNT, 32'h0);
    chk(q - c0, t_smp - t0);
    u_src.hold(0, 0, 1'b1);
    repeat (6) @(posedge mclk_i);
    pend(32'h1, 32'h1);
    u_src.hold(0, 0, 1'b0);
    repeat (6) @(posedge mclk_i);
    pend(32'h1, 32'h0);
    // Edge line left high: clearing must not re-latch it
    u_src.hold(0, 1, 1'b1);
    repeat (6) @(posedge mclk_i);
    pend(32'h2, 32'h2);
    bus(1'b1, CITL_OFS_ENAB, 32'h2);
    repeat (4) @(posedge mclk_i);
    chk({26'h0, disp_valid_o, disp_c_ok_o, disp_level_o}, 32'h33);
    bus(1'b0, CITL_OFS_DISP, 32'h0);
    chk(q, 32'h0000_0033);
    bus(1'b1, CITL_OFS_CLVL, 32'h3);
    repeat (4) @(posedge mclk_i);
    chk({31'h0, disp_valid_o}, 32'h0);
    bus(1'b1, CITL_OFS_CLVL, 32'h0);
    bus(1'b1, CITL_OFS_PCLR, 32'h2);
    pend(32'h2, 32'h0);
    u_src.hold(0, 1, 1'b0);
    bus(1'b1, CITL_OFS_PSET, 32'h8);
    pend(32'h8, 32'h8);
    bus(1'b1, CITL_OFS_PCLR, 32'h8);
    pend(32'h8, 32'h0);
    u_src.hold(3, 2, 1'b1);
    repeat (3) @(posedge mclk_i);
    pend(32'h4, 32'h4);
    u_src.hold(3, 2, 1'b0);
    u_src.pulse(2, 0);
    repeat (6) @(posedge mclk_i);
    pend(32'h1000_0000, 32'h1000_0000);
    bus(1'b1, CITL_OFS_ISTAT, 32'hF);
    bus(1'b1, CITL_OFS_IMASK, 32'h8);
    bus(1'b0, CITL_OFS_CCNT, 32'h0);
    bus(1'b1, CITL_OFS_CMP0, q + 32'h64);
    pend(32'h2000_0000, 32'h0);
    repeat (120) @(posedge mclk_i);
    pend(32'h2000_0000, 32'h2000_0000);
    irq_is(1'b1);
    bus(1'b1, CITL_OFS_IMASK, 32'h0);
    irq_is(1'b0);
    bus(1'b1, CITL_OFS_ISTAT, 32'h8);
    bus(1'b1, CITL_OFS_IMASK, 32'h8);
    irq_is(1'b0);
    bus(1'b1, CITL_OFS_CLVL, 32'hF);
    u_src.pulse(1, 0);
    repeat (6) @(posedge mclk_i);
    chk({27'h0, disp_nmi_o, disp_level_o}, 32'h1F);
    bus(1'b1, CITL_OFS_DISP, 32'h8000_0000);
    repeat (3) @(posedge mclk_i);
    chk({31'h0, disp_nmi_o}, 32'h0);
    close_out();
  end
endmodule

//--- design/citl_pkg.sv
package citl_pkg;
  localparam logic [7:0] CITL_OFS_PEND = 8'h00;
  localparam logic [7:0] CITL_OFS_PSET = 8'h04;
  localparam logic [7:0] CITL_OFS_PCLR = 8'h08;
  localparam logic [7:0] CITL_OFS_ENAB = 8'h0C;
  localparam logic [7:0] CITL_OFS_CLVL = 8'h10;
  localparam logic [7:0] CITL_OFS_DISP = 8'h14;
  localparam logic [7:0] CITL_OFS_CCNT = 8'h18;
  localparam logic [7:0] CITL_OFS_CMP0 = 8'h1C;
  localparam logic [7:0] CITL_OFS_CMP1 = 8'h20;
  localparam logic [7:0] CITL_OFS_CMP2 = 8'h24;
  localparam logic [7:0] CITL_OFS_ISTAT = 8'h28;
  localparam logic [7:0] CITL_OFS_IMASK = 8'h2C;
  localparam logic [7:0] CITL_OFS_CFG = 8'h30;
  localparam logic [31:0] CITL_ENAB_RST = 32'h0000_0000;
  localparam logic [31:0] CITL_CMP_RST = 32'hFFFF_FFFF;
  localparam logic [3:0] CITL_CLVL_RST = 4'h0;
  localparam logic [3:0] CITL_NMI_LEVEL = 4'hF;
  localparam logic [1:0] CITL_TYPE_LEVEL = 2'h0;
  localparam logic [1:0] CITL_TYPE_EDGE = 2'h1;
  localparam logic [1:0] CITL_TYPE_INT = 2'h2;
  localparam logic [1:0] CITL_TYPE_SW = 2'h3;
  localparam int CITL_EV_DISP = 0;
  localparam int CITL_EV_NMI = 1;
  localparam int CITL_EV_WERR = 2;
  localparam int CITL_EV_TMR = 3;
  localparam int CITL_EV_W = 4;
  localparam int CITL_MAX_SRC = 32;
  localparam int CITL_MIN_HI_LVL = 2;
  localparam int CITL_MAX_HI_LVL = 15;
  typedef enum logic [2:0] {
    CITL_BUS_IDLE = 3'b001,
    CITL_BUS_ACK = 3'b010,
    CITL_BUS_DONE = 3'b100
  } citl_bus_t;
endpackage

//--- design/citl_sync.sv
`timescale 1ns/1ps
module citl_sync
  import citl_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

//--- design/citl_timer.sv
`timescale 1ns/1ps
module citl_timer
  import citl_pkg::*;
#(
  parameter int NTMR = 3
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Comparator write
  input wire logic [NTMR-1:0] cmp_we_i,
  input wire logic [31:0] cmp_wdata_i,
  // Status
  output logic [31:0] ccount_o,
  output logic [NTMR*32-1:0] cmp_o,
  output logic [NTMR-1:0] match_o
);
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      ccount_o <= '0;
    else
      ccount_o <= ccount_o + 32'h0000_0001;
  end

  // One process owns every comparison register
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      cmp_o <= {NTMR{CITL_CMP_RST}};
    else
      for (int t = 0; t < NTMR; t++)
        if (cmp_we_i[t])
          cmp_o[t*32 +: 32] <= cmp_wdata_i;
  end

  genvar g;
  generate
    for (g = 0; g < NTMR; g++)
    begin : g_cmp
      assign match_o[g] = (cmp_o[g*32 +: 32] == ccount_o);
    end
  endgenerate
endmodule

//--- design/citl_top.sv
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module citl_top
  import citl_pkg::*;
#(
  parameter int NSRC = 32,
  parameter logic [NSRC*2-1:0] SRC_TYPE = {NSRC{CITL_TYPE_EDGE}},
  parameter logic [NSRC*4-1:0] SRC_LEVEL = {NSRC{4'h1}},
  parameter int NTMR = 3,
  parameter int TMR_SLOT0 = 29,
  parameter int WERR_SLOT = 28,
  parameter bit HAS_WERR = 1'b1,
  parameter bit HAS_NMI = 1'b1,
  parameter logic [3:0] c_callable_level_limit = 4'h3
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt sources
  input wire logic [NSRC-1:0] irq_i,
  input wire logic nmi_i,
  input wire logic wr_resp_err_i,
  input wire logic [NSRC-1:0] int_src_i,
  // Dispatch to pipeline
  output logic disp_valid_o,
  output logic [3:0] disp_level_o,
  output logic disp_nmi_o,
  output logic disp_c_ok_o,
  output logic irq_o
);
  localparam logic [NSRC*2-1:0] TYPE_P = SRC_TYPE;

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
      m[i*8 +: 8] = {8{be[i]}};
    return m;
  endfunction

  function automatic logic is_type(input int s, input logic [1:0] t);
    return TYPE_P[s*2 +: 2] == t;
  endfunction

  logic [NSRC-1:0] irq_s;
  logic nmi_s;
  logic werr_s;
  logic [NSRC-1:0] irq_d_r;
  logic nmi_d_r;
  logic werr_d_r;
  logic [NSRC-1:0] latch_r;
  logic [NSRC-1:0] sw_r;
  logic [NSRC-1:0] enab_r;
  logic [3:0] clvl_r;
  logic nmi_pend_r;
  logic [CITL_EV_W-1:0] istat_r;
  logic [CITL_EV_W-1:0] imask_r;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] src_set;
  logic [31:0] ccount;
  logic [NTMR*32-1:0] cmp;
  logic [NTMR-1:0] match;
  logic [NTMR-1:0] cmp_we;
  logic [3:0] best_lvl;
  logic disp_take;
  logic [CITL_EV_W-1:0] ev;
  citl_bus_t bus_r;
  logic wr_acc;
  logic [31:0] wmask;
  logic [31:0] rd_nxt;

  citl_sync #(.W(NSRC)) u_sync_irq (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(irq_i),
    .q_o(irq_s)
  );

  citl_sync #(.W(2)) u_sync_misc (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i({nmi_i, wr_resp_err_i}),
    .q_o({nmi_s, werr_s})
  );

  citl_timer #(.NTMR(NTMR)) u_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .cmp_we_i(cmp_we),
    .cmp_wdata_i(avs_writedata),
    .ccount_o(ccount),
    .cmp_o(cmp),
    .match_o(match)
  );

  // Bus handshake: accept in IDLE, answer one cycle later
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      bus_r <= CITL_BUS_IDLE;
    else
      case (bus_r)
        CITL_BUS_IDLE:
          if (avs_read || avs_write)
            bus_r <= CITL_BUS_ACK;
        CITL_BUS_ACK:
          bus_r <= CITL_BUS_DONE;
        CITL_BUS_DONE:
          bus_r <= CITL_BUS_IDLE;
        default:
          bus_r <= CITL_BUS_IDLE;
      endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !(bus_r == CITL_BUS_IDLE && (avs_read || avs_write));
  end

  assign wr_acc = avs_write && bus_r == CITL_BUS_ACK;
  assign wmask = be_mask(avs_byteenable);

  always_comb
  begin
    cmp_we = '0;
    for (int t = 0; t < NTMR; t++)
      if (wr_acc && avs_address == CITL_OFS_CMP0 + 8'(t * 4))
        cmp_we[t] = 1'b1;
  end

  // Source classification and latched edges
  always_comb
  begin
    src_set = '0;
    for (int s = 0; s < NSRC; s++)
    begin
      if (is_type(s, CITL_TYPE_EDGE) && irq_s[s] && !irq_d_r[s])
        src_set[s] = 1'b1;
      if (is_type(s, CITL_TYPE_INT) && int_src_i[s])
        src_set[s] = 1'b1;
    end
    for (int t = 0; t < NTMR; t++)
      if (match[t] && TMR_SLOT0 + t < NSRC)
        src_set[TMR_SLOT0 + t] = 1'b1;
    if (HAS_WERR && werr_s && !werr_d_r && WERR_SLOT < NSRC)
      src_set[WERR_SLOT] = 1'b1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      irq_d_r <= '0;
      nmi_d_r <= 1'b0;
      werr_d_r <= 1'b0;
    end
    else
    begin
      irq_d_r <= irq_s;
      nmi_d_r <= nmi_s;
      werr_d_r <= werr_s;
    end
  end

  // Latched requests: set wins over software clear
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      latch_r <= '0;
    else if (wr_acc && avs_address == CITL_OFS_PCLR)
      latch_r <= (latch_r & ~NSRC'(avs_writedata & wmask)) | src_set;
    else
      latch_r <= latch_r | src_set;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      sw_r <= '0;
    else
      for (int s = 0; s < NSRC; s++)
        if (is_type(s, CITL_TYPE_SW) && wr_acc && wmask[s])
        begin
          if (avs_address == CITL_OFS_PSET && avs_writedata[s])
            sw_r[s] <= 1'b1;
          else if (avs_address == CITL_OFS_PCLR && avs_writedata[s])
            sw_r[s] <= 1'b0;
        end
  end

  always_comb
  begin
    for (int s = 0; s < NSRC; s++)
      pend[s] = is_type(s, CITL_TYPE_LEVEL) ? irq_s[s] :
                (latch_r[s] | sw_r[s]);
  end

  // Enables and current level
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      enab_r <= NSRC'(CITL_ENAB_RST);
      clvl_r <= CITL_CLVL_RST;
    end
    else
    begin
      if (wr_acc && avs_address == CITL_OFS_ENAB)
        enab_r <= (enab_r & ~NSRC'(wmask)) | NSRC'(avs_writedata & wmask);
      if (wr_acc && avs_address == CITL_OFS_CLVL && avs_byteenable[0])
        clvl_r <= avs_writedata[3:0];
    end
  end

  // Highest level among pending enabled sources
  always_comb
  begin
    best_lvl = '0;
    for (int s = 0; s < NSRC; s++)
      if (pend[s] && enab_r[s] && SRC_LEVEL[s*4 +: 4] > best_lvl)
        best_lvl = SRC_LEVEL[s*4 +: 4];
  end

  // Unmaskable edge latch
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      nmi_pend_r <= 1'b0;
    else if (HAS_NMI && nmi_s && !nmi_d_r)
      nmi_pend_r <= 1'b1;
    else if (wr_acc && avs_address == CITL_OFS_DISP && avs_writedata[31])
      nmi_pend_r <= 1'b0;
  end

  assign disp_take = nmi_pend_r || best_lvl > clvl_r;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      disp_valid_o <= 1'b0;
      disp_level_o <= '0;
      disp_nmi_o <= 1'b0;
      disp_c_ok_o <= 1'b0;
    end
    else
    begin
      disp_valid_o <= disp_take;
      disp_nmi_o <= nmi_pend_r;
      disp_level_o <= nmi_pend_r ? CITL_NMI_LEVEL :
                      (disp_take ? best_lvl : 4'h0);
      disp_c_ok_o <= !nmi_pend_r && disp_take &&
                     (best_lvl == 4'h1 ||
                      best_lvl <= c_callable_level_limit);
    end
  end

  // Interrupt status events
  always_comb
  begin
    ev = '0;
    ev[CITL_EV_DISP] = disp_take && !disp_valid_o;
    ev[CITL_EV_NMI] = HAS_NMI && nmi_s && !nmi_d_r;
    ev[CITL_EV_WERR] = HAS_WERR && werr_s && !werr_d_r;
    ev[CITL_EV_TMR] = |match;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      istat_r <= '0;
      imask_r <= '0;
    end
    else
    begin
      if (wr_acc && avs_address == CITL_OFS_ISTAT)
        istat_r <= (istat_r & ~avs_writedata[CITL_EV_W-1:0]) | ev;
      else
        istat_r <= istat_r | ev;
      if (wr_acc && avs_address == CITL_OFS_IMASK && avs_byteenable[0])
        imask_r <= avs_writedata[CITL_EV_W-1:0];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(istat_r & imask_r);
  end

  // Read mux
  always_comb
  begin
    rd_nxt = '0;
    case (avs_address)
      CITL_OFS_PEND: rd_nxt = 32'(pend);
      CITL_OFS_ENAB: rd_nxt = 32'(enab_r);
      CITL_OFS_CLVL: rd_nxt = {28'h0, clvl_r};
      CITL_OFS_DISP: rd_nxt = {nmi_pend_r, 23'h0, c_callable_level_limit,
                               best_lvl};
      CITL_OFS_CCNT: rd_nxt = ccount;
      CITL_OFS_ISTAT: rd_nxt = 32'(istat_r);
      CITL_OFS_IMASK: rd_nxt = 32'(imask_r);
      CITL_OFS_CFG: rd_nxt = {16'h0, 6'(NSRC), 2'(NTMR), 6'h0,
                              HAS_WERR, HAS_NMI};
      default:
        for (int t = 0; t < NTMR; t++)
          if (avs_address == CITL_OFS_CMP0 + 8'(t * 4))
            rd_nxt = cmp[t*32 +: 32];
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      avs_readdata <= '0;
    else if (bus_r == CITL_BUS_IDLE && avs_read)
      avs_readdata <= rd_nxt;
  end
endmodule
